/* File: logic/bds_consts.svh */
// timing constants for the background debug speed-synchronisation exchange
`ifndef BDS_CONSTS_SVH
`define BDS_CONSTS_SVH
`define BDS_RESP_LOW_CYC 128
`define BDS_SETTLE_CYC 16
`define BDS_SPEEDUP_CYC 1
`define BDS_REQ_MIN_SLOW_CYC 128
`define BDS_SLOW_DIV 64
`define BDS_REQ_THRESH_CYC 512
`define BDS_CNT_W 16
`endif

/* File: logic/bds_pkg.sv */
// types shared by both ends of the speed-synchronisation exchange
`default_nettype none
package bds_pkg;
    typedef enum logic [2:0] {
        BDS_T_IDLE = 3'h0,
        BDS_T_WAIT_HIGH = 3'h1,
        BDS_T_SETTLE = 3'h2,
        BDS_T_DRIVE_LOW = 3'h3,
        BDS_T_SPEEDUP = 3'h4
    } bds_tgt_state_t;
    typedef enum logic [2:0] {
        BDS_H_IDLE = 3'h0,
        BDS_H_REQ_LOW = 3'h1,
        BDS_H_SPEEDUP = 3'h2,
        BDS_H_WAIT_FALL = 3'h3,
        BDS_H_MEASURE = 3'h4
    } bds_host_state_t;
endpackage
`default_nettype wire

/* File: logic/bds_link_if.sv */
// single-wire background debug pin shared by host and target
`timescale 1ns/1ns
`default_nettype none
interface bds_link_if;
    logic tgt_out;
    logic tgt_oe;
    logic host_out;
    logic host_oe;
    logic pin_level;
    // pulled-up open wire: low wins if anyone drives low
    assign pin_level = !((tgt_oe && !tgt_out) || (host_oe && !host_out));
    modport target (output tgt_out, output tgt_oe, input pin_level);
    modport host (output host_out, output host_oe, input pin_level);
endinterface
`default_nettype wire

/* File: logic/bds_target.sv */
// target end: detects a long low request and answers with a 128-cycle low pulse
// How it works
// - host syncs before knowing target speed
// - host request low lasts 128 slow cycles
// - slowest clock is source divided by 64
// - host ends request with brief high pulse
// - host then releases pin and listens
// - target spots request by very long low
// - target waits for pin back high
// - target then waits 16 debug cycles
// - target drives pin low 128 cycles
// - target drives one-cycle high speedup pulse
// - target then releases the pin
// - host times low part, sets bit timing
// - several percent speed mismatch is tolerated
`timescale 1ns/1ns
`default_nettype none
`include "bds_consts.svh"
// parameter guidance:
//  cnt_w sizes the one phase counter; it must hold the request threshold
//  req_thresh is counted in target cycles; keep it well above any bit-time
//  low of normal traffic, and below the host request length in target cycles
//  resp_low is the answer length that the host divides by to find our speed
//  settle is the quiet time that lets the host drop its speedup drive
// limitation: a host that keeps the pin low past the threshold is fine, the
// sequencer simply waits; a host that never releases it holds us in wait
module bds_target #(
    parameter int CNT_W = `BDS_CNT_W,
    parameter int REQ_THRESH = `BDS_REQ_THRESH_CYC,
    parameter int RESP_LOW = `BDS_RESP_LOW_CYC,
    parameter int SETTLE = `BDS_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    bds_link_if.target link,
    output logic sync_busy,
    output logic sync_done
);
    // overview of the sequencer, one state per phase of the answer:
    //  idle: pin low samples are counted; any high sample clears the count,
    //  so ordinary bit-time lows never reach the threshold
    //  wait_high: request seen; the host may hold the pin low as long as
    //  it likes, so nothing is timed here
    //  settle: counted from the first high sample, giving the host time
    //  to take its own speedup drive off the wire
    //  drive_low: the answer itself, timed in our own clock so the host
    //  can derive our speed from its length
    //  speedup: one cycle of active high to sharpen the rising edge
    // pin drive is registered, so each drive change shows one cycle after
    // the decision that asks for it; the drive group below therefore looks
    // at the same terminal counts as the sequencer, one cycle ahead
    // clk_en low holds every register and stretches the running phase;
    // the host must be frozen alike or the measured length is wrong
    // a reset in mid-answer drops the drive at the next clock edge; a host still measuring
    // then sees the pin rise early and reports the short low count as valid

    // sequencer state and the single phase counter
    bds_pkg::bds_tgt_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    // registered pin drive and completion pulse
    logic done_reg, done_next;
    logic oe_reg, oe_next;
    logic out_reg, out_next;

    // true on the last counted cycle of a phase that lasts len cycles
    function automatic logic phase_end(input logic [CNT_W-1:0] cnt, input int len);
        return cnt == CNT_W'(len - 1);
    endfunction

    // sequencer: next state and phase count
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            bds_pkg::BDS_T_IDLE: begin
                if (!link.pin_level) begin
                    // count low time; stop at threshold
                    if (cnt_reg >= CNT_W'(REQ_THRESH - 1)) begin
                        state_next = bds_pkg::BDS_T_WAIT_HIGH;
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end else begin
                    // short lows are normal traffic
                    cnt_next = '0;
                end
            end
            bds_pkg::BDS_T_WAIT_HIGH: begin
                // host still owns the wire
                if (link.pin_level) begin
                    state_next = bds_pkg::BDS_T_SETTLE;
                    cnt_next = '0;
                end
            end
            bds_pkg::BDS_T_SETTLE: begin
                if (phase_end(cnt_reg, SETTLE)) begin
                    state_next = bds_pkg::BDS_T_DRIVE_LOW;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            bds_pkg::BDS_T_DRIVE_LOW: begin
                if (phase_end(cnt_reg, RESP_LOW)) begin
                    state_next = bds_pkg::BDS_T_SPEEDUP;
                    cnt_next = '0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            bds_pkg::BDS_T_SPEEDUP: begin
                // one cycle only, then back to listening
                state_next = bds_pkg::BDS_T_IDLE;
                cnt_next = '0;
            end
            default: begin
                state_next = bds_pkg::BDS_T_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    // sequencer registers, frozen while clk_en is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= bds_pkg::BDS_T_IDLE;
            cnt_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // drive group: pin drive one cycle ahead of the phase it belongs to
    always_comb begin
        oe_next = 1'b0;
        out_next = 1'b1;
        done_next = 1'b0;
        case (state_reg)
            bds_pkg::BDS_T_SETTLE: begin
                // start pulling low as the settle time runs out
                if (phase_end(cnt_reg, SETTLE)) begin
                    oe_next = 1'b1;
                    out_next = 1'b0;
                end
            end
            bds_pkg::BDS_T_DRIVE_LOW: begin
                // low, then high on the last low cycle for the speedup
                oe_next = 1'b1;
                out_next = phase_end(cnt_reg, RESP_LOW);
            end
            bds_pkg::BDS_T_SPEEDUP: begin
                // drive drops here; report the finished answer
                done_next = 1'b1;
            end
            default: begin
                oe_next = 1'b0;
                out_next = 1'b1;
            end
        endcase
    end

    // drive registers, frozen while clk_en is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
            oe_reg <= 1'b0;
            out_reg <= 1'b1;
        end else if (clk_en) begin
            done_reg <= done_next;
            oe_reg <= oe_next;
            out_reg <= out_next;
        end
    end

    // pin drive only during own response phases
    assign link.tgt_oe = oe_reg;
    assign link.tgt_out = out_reg;
    assign sync_busy = (state_reg != bds_pkg::BDS_T_IDLE);
    assign sync_done = done_reg;
endmodule // bds_target
`default_nettype wire

/* File: logic/bds_host.sv */
// host end: issues a sync request and measures the target response pulse
`timescale 1ns/1ns
`default_nettype none
`include "bds_consts.svh"
module bds_host #(
    parameter int CNT_W = `BDS_CNT_W,
    parameter int REQ_LOW = `BDS_REQ_THRESH_CYC * 2,
    parameter int TIMEOUT = 16'hfff0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    bds_link_if.host link,
    input wire logic sync_start,
    output logic sync_busy,
    output logic sync_valid,
    output logic sync_timeout,
    output logic [CNT_W-1:0] low_cycles
);
    bds_pkg::bds_host_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] meas_reg, meas_next;
    logic valid_reg, valid_next;
    logic tmo_reg, tmo_next;
    logic oe_reg, oe_next;
    logic out_reg, out_next;

    // request, speedup, release, then time the low response
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        meas_next = meas_reg;
        valid_next = 1'b0;
        tmo_next = 1'b0;
        oe_next = 1'b0;
        out_next = 1'b1;
        case (state_reg)
            bds_pkg::BDS_H_IDLE: begin
                if (sync_start) begin
                    state_next = bds_pkg::BDS_H_REQ_LOW;
                    cnt_next = '0;
                    oe_next = 1'b1;
                    out_next = 1'b0;
                end
            end
            bds_pkg::BDS_H_REQ_LOW: begin
                oe_next = 1'b1;
                if (cnt_reg == CNT_W'(REQ_LOW - 1)) begin
                    state_next = bds_pkg::BDS_H_SPEEDUP;
                    out_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                    out_next = 1'b0;
                end
            end
            bds_pkg::BDS_H_SPEEDUP: begin
                state_next = bds_pkg::BDS_H_WAIT_FALL;
                cnt_next = '0;
            end
            bds_pkg::BDS_H_WAIT_FALL: begin
                if (!link.pin_level) begin
                    state_next = bds_pkg::BDS_H_MEASURE;
                    cnt_next = CNT_W'(1);
                end else if (cnt_reg == CNT_W'(TIMEOUT)) begin
                    state_next = bds_pkg::BDS_H_IDLE;
                    tmo_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            bds_pkg::BDS_H_MEASURE: begin
                if (link.pin_level) begin
                    state_next = bds_pkg::BDS_H_IDLE;
                    meas_next = cnt_reg;
                    valid_next = 1'b1;
                end else if (cnt_reg == {CNT_W{1'b1}}) begin
                    state_next = bds_pkg::BDS_H_IDLE;
                    tmo_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = bds_pkg::BDS_H_IDLE;
            end
        endcase
    end

    // state registers, frozen while clk_en is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= bds_pkg::BDS_H_IDLE;
            cnt_reg <= '0;
            meas_reg <= '0;
            valid_reg <= 1'b0;
            tmo_reg <= 1'b0;
            oe_reg <= 1'b0;
            out_reg <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            meas_reg <= meas_next;
            valid_reg <= valid_next;
            tmo_reg <= tmo_next;
            oe_reg <= oe_next;
            out_reg <= out_next;
        end
    end

    // host drives only during request and its speedup
    assign link.host_oe = oe_reg;
    assign link.host_out = out_reg;
    assign sync_busy = (state_reg != bds_pkg::BDS_H_IDLE);
    assign sync_valid = valid_reg;
    assign sync_timeout = tmo_reg;
    assign low_cycles = meas_reg;
endmodule // bds_host
`default_nettype wire

/* File: tb/bds_link_monitor.sv */
// concurrent checks on the shared background debug pin
`timescale 1ns/1ns
`default_nettype none
module bds_link_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic tgt_out,
    input wire logic tgt_oe,
    input wire logic host_out,
    input wire logic host_oe,
    input wire logic pin_level
);
    logic [7:0] tlo_reg;
    logic [7:0] hi_reg;
    logic [10:0] hlo_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // run lengths of target low, pin high and host low, in enabled cycles
    always_ff @(posedge clk) begin
        tlo_reg <= (sys_rst || !(tgt_oe && !tgt_out)) ? 8'h0 : tlo_reg + {7'h0, clk_en};
        hi_reg <= (sys_rst || !pin_level) ? 8'h0 :
            hi_reg + {7'h0, clk_en && hi_reg != 8'hff};
        hlo_reg <= (sys_rst || !(host_oe && !host_out)) ? 11'h0 : hlo_reg + {10'h0, clk_en};
    end
    a_resp_low_len: assert property ((tgt_oe && tgt_out) |-> tlo_reg == 8'h80)
        else $error("target response low length wrong");
    a_tgt_speedup_one: assert property ((tgt_oe && tgt_out) |=> !tgt_oe)
        else $error("target speedup longer than one cycle");
    a_tgt_release: assert property ($fell(tgt_oe) |-> $past(tgt_out))
        else $error("target released without speedup");
    a_resp_starts_low: assert property ($rose(tgt_oe) |-> !tgt_out)
        else $error("target response does not start low");
    a_settle_delay: assert property ($rose(tgt_oe) |-> hi_reg inside {[8'h10:8'h12]})
        else $error("target settle delay wrong");
    a_no_clash: assert property (!(tgt_oe && host_oe))
        else $error("both ends drive the pin");
    a_host_req_len: assert property ((host_oe && host_out) |-> hlo_reg == 11'h400)
        else $error("host request low length wrong");
    a_host_release: assert property ((host_oe && host_out) |=> !host_oe)
        else $error("host speedup not followed by release");
    a_host_starts_low: assert property ($rose(host_oe) |-> !host_out)
        else $error("host request does not start low");
    // main scenarios
    c_response: cover property ($rose(tgt_oe));
    c_host_speedup: cover property (host_oe && host_out);
    c_tgt_done: cover property ($fell(tgt_oe));
    c_frozen_low: cover property (!clk_en && tgt_oe);
endmodule // bds_link_monitor
`default_nettype wire

/* File: tb/tb_background_debug_sync.sv */
// self-checking bench: host and target ends joined over the debug pin
`timescale 1ns/1ns
`default_nettype none
module tb_background_debug_sync;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic sync_start = 1'b0;
    logic h_busy, h_valid, h_tmo, t_busy, t_done;
    logic [15:0] low_cycles;
    int err_total = 0;
    int total_checks = 0;
    int done_seen;
    bds_link_if link ();
    bds_target bds_target_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .link(link.target), .sync_busy(t_busy), .sync_done(t_done));
    bds_host bds_host_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .link(link.host), .sync_start(sync_start), .sync_busy(h_busy),
        .sync_valid(h_valid), .sync_timeout(h_tmo), .low_cycles(low_cycles));
    bds_link_monitor bds_link_monitor_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .tgt_out(link.tgt_out), .tgt_oe(link.tgt_oe), .host_out(link.host_out),
        .host_oe(link.host_oe), .pin_level(link.pin_level));
    // 50 ns clock
    always #25 clk = ~clk;
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task stop_test;
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one exchange; poke raises a second start while busy, frz stalls both ends
    task run_sync(input logic poke, input logic frz);
        int n;
        n = 0;
        done_seen = 0;
        @(negedge clk) sync_start = 1'b1;
        @(negedge clk) sync_start = 1'b0;
        while (h_valid !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
            done_seen += (t_done === 1'b1);
            sync_start = poke && n == 600;
            clk_en = !(frz && n >= 1100 && n < 1110);
        end
        if (n >= 4000) begin
            chk("valid wait", 16'h0001, 16'h0000);
            stop_test();
        end
        chk("timeout flag", 16'h0000, {15'h0, h_tmo});
        chk("low_cycles", 16'h0080, low_cycles);
        repeat (4) @(negedge clk) done_seen += (t_done === 1'b1);
        chk("sync_done", 16'h0001, 16'(done_seen));
        chk("busy and drive", 16'h0001, {11'h0, link.host_oe, link.tgt_oe, h_busy, t_busy,
            link.pin_level});
    endtask
    initial begin
        repeat (8) @(negedge clk);
        chk("reset idle", 16'h0001, {11'h0, link.tgt_oe, link.host_oe, h_busy, t_busy,
            link.pin_level});
        sys_rst = 1'b0;
        run_sync(1'b1, 1'b0);
        run_sync(1'b0, 1'b0);
        // reset in mid-response, then recover
        @(negedge clk) sync_start = 1'b1;
        @(negedge clk) sync_start = 1'b0;
        repeat (1100) @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk("mid reset", 16'h0001, {11'h0, link.tgt_oe, link.host_oe, h_busy, t_busy,
            link.pin_level});
        chk("cleared count", 16'h0000, low_cycles);
        run_sync(1'b0, 1'b1);
        stop_test();
    end
endmodule // tb_background_debug_sync
`default_nettype wire
